// ### hdl/svim_top.sv
`default_nettype none
module svim_top
    import svim_pkg::*;
#(
    parameter logic [15:0] ID_VALUE = 16'h5a01 // Arbitrary identification value
)(
    input wire logic ref_clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral event pulses
    input wire logic can1_evt,
    input wire logic can2_evt,
    input wire logic i2c_rx_evt,
    input wire logic i2c_tx_evt,
    input wire logic i2c_err_evt,
    input wire logic second_sync_serial_rx_evt,
    input wire logic second_sync_serial_tx_evt,
    input wire logic second_sync_serial_err_evt,
    input wire logic second_async_serial_rx_evt,
    input wire logic second_async_serial_tx_evt,
    input wire logic second_async_serial_tbuf_evt,
    input wire logic second_async_serial_err_evt,
    input wire logic pll_unlock_oscillator_watchdog_evt,
    input wire logic second_pwm_unit_evt,
    // Exception sources from the CPU
    input wire logic hw_reset_req,
    input wire logic sw_reset_req,
    input wire logic wdt_overflow_req,
    input wire logic nmi_req,
    input wire logic stack_overflow_flag,
    input wire logic stack_underflow_flag,
    input wire logic undefined_opcode_flag,
    input wire logic multiply_accum_trap_flag,
    input wire logic protected_instr_fault_flag,
    input wire logic illegal_operand_flag,
    input wire logic illegal_fetch_flag,
    input wire logic illegal_ext_bus_flag,
    input wire logic soft_trap_req,
    input wire logic [6:0] soft_trap_num,
    input wire logic [3:0] cpu_ilvl_in,
    input wire logic trap_return,
    // To the CPU sequencer
    output logic [SVIM_NUM_VEC-1:0] shared_vector_req,
    output logic trap_valid,
    output logic [8:0] trap_vector_loc,
    output logic [6:0] trap_number,
    output logic [3:0] cpu_priority_level,
    output logic std_irq_block,
    output logic irq
);
    initial begin
        if (SVIM_NUM_VEC != 4 || SVIM_NUM_SRC != 8) begin
            $error("svim_top supports four vectors of eight sources only");
        end
    end

    // Per-source event vector, one bit per peripheral event input
    logic [SVIM_NUM_PER-1:0] per_evt;
    assign per_evt = {second_pwm_unit_evt, pll_unlock_oscillator_watchdog_evt,
                      second_async_serial_err_evt, second_async_serial_tbuf_evt,
                      second_async_serial_tx_evt, second_async_serial_rx_evt,
                      second_sync_serial_err_evt, second_sync_serial_tx_evt,
                      second_sync_serial_rx_evt, i2c_err_evt, i2c_tx_evt, i2c_rx_evt,
                      can2_evt, can1_evt};

    // Routing: source bit positions within each flag byte
    logic [SVIM_NUM_SRC-1:0] vec_evt [SVIM_NUM_VEC];
    // Error sources stay off vectors 0 to 2, so each of those bytes holds exactly eight sources
    assign vec_evt[0] = {per_evt[10], per_evt[9], per_evt[8], per_evt[6], per_evt[5], per_evt[3],
                         per_evt[2], per_evt[0]};
    assign vec_evt[1] = {per_evt[10], per_evt[9], per_evt[8], per_evt[6], per_evt[5], per_evt[3],
                         per_evt[2], per_evt[1]};
    assign vec_evt[2] = {per_evt[13], per_evt[10], per_evt[9], per_evt[8], per_evt[6], per_evt[5],
                         per_evt[3], per_evt[2]};
    assign vec_evt[3] = {per_evt[13], per_evt[12], per_evt[11], per_evt[7], per_evt[4],
                         per_evt[1], per_evt[0], 1'b0};

    // APB decode
    logic apb_wr;
    logic apb_rd;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign pready = 1'b1;

    logic known_addr;
    always_comb begin
        if (paddr == SVIM_ADDR_SEL0 || paddr == SVIM_ADDR_SEL1 || paddr == SVIM_ADDR_SEL2) begin
            known_addr = 1'b1;
        end else if (paddr == SVIM_ADDR_SEL3 || paddr == SVIM_ADDR_TFR || paddr == SVIM_ADDR_EXC) begin
            known_addr = 1'b1;
        end else if (paddr == SVIM_ADDR_IST || paddr == SVIM_ADDR_IMSK || paddr == SVIM_ADDR_ID) begin
            known_addr = 1'b1;
        end else begin
            known_addr = 1'b0;
        end
    end
    assign pslverr = psel && penable && !known_addr;

    logic [15:0] sel_value [SVIM_NUM_VEC];
    genvar gv;
    generate
        for (gv = 0; gv < SVIM_NUM_VEC; gv++) begin : g_vec
            svim_vector_slice u_slice (
                .ref_clk(ref_clk),
                .reset(reset),
                .event_in(vec_evt[gv]),
                .wr_en(apb_wr && paddr == SVIM_ADDR_SEL0 + 12'(4 * gv)),
                .wr_data(pwdata[15:0]),
                .wr_strb(pstrb[1:0]),
                .sel_value(sel_value[gv]),
                .vec_req(shared_vector_req[gv])
            );
        end
    endgenerate

    // Trap flag register: hardware sets win over software clear-by-write-zero
    logic [15:0] trap_flag_register;
    logic [15:0] tf_set;
    always_comb begin
        tf_set = 16'h0000;
        tf_set[SVIM_TF_NMI] = nmi_req;
        tf_set[SVIM_TF_STACK_OVERFLOW_FLAG] = stack_overflow_flag;
        tf_set[SVIM_TF_STKUF] = stack_underflow_flag;
        tf_set[SVIM_TF_UNDOP] = undefined_opcode_flag;
        tf_set[SVIM_TF_MACTR] = multiply_accum_trap_flag;
        tf_set[SVIM_TF_PRTFL] = protected_instr_fault_flag;
        tf_set[SVIM_TF_ILLOP] = illegal_operand_flag;
        tf_set[SVIM_TF_ILLIN] = illegal_fetch_flag;
        tf_set[SVIM_TF_ILLBS] = illegal_ext_bus_flag;
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            trap_flag_register <= 16'h0000;
        end else if (apb_wr && paddr == SVIM_ADDR_TFR) begin
            trap_flag_register <= (pwdata[15:0] & trap_flag_register) | tf_set;
        end else begin
            trap_flag_register <= trap_flag_register | tf_set;
        end
    end

    // Exception arbitration
    logic any_reset;
    logic class_a;
    logic class_b;
    assign any_reset = hw_reset_req | sw_reset_req | wdt_overflow_req;
    assign class_a = nmi_req | stack_overflow_flag | stack_underflow_flag;
    assign class_b = |(tf_set & SVIM_TF_CLASS_B);

    svim_exc_e active_class;
    svim_exc_e req_class;
    logic [8:0] next_loc;
    logic [6:0] next_num;
    always_comb begin
        req_class = SVIM_EXC_NONE;
        next_loc = SVIM_VLOC_RESET;
        next_num = SVIM_TNUM_RESET;
        if (any_reset) begin
            req_class = SVIM_EXC_RESET;
        end else if (class_a) begin
            req_class = SVIM_EXC_CLASS_A;
            if (nmi_req) begin
                next_loc = SVIM_VLOC_NMI;
                next_num = SVIM_TNUM_NMI;
            end else if (stack_overflow_flag) begin
                next_loc = SVIM_VLOC_STACK_OVERFLOW_FLAG;
                next_num = SVIM_TNUM_STACK_OVERFLOW_FLAG;
            end else begin
                next_loc = SVIM_VLOC_STKUF;
                next_num = SVIM_TNUM_STKUF;
            end
        end else if (class_b) begin
            req_class = SVIM_EXC_CLASS_B;
            next_loc = SVIM_VLOC_CLASS_B;
            next_num = SVIM_TNUM_CLASS_B;
        end else if (soft_trap_req) begin
            req_class = SVIM_EXC_SOFT;
            next_loc = {soft_trap_num, 2'b00};
            next_num = soft_trap_num;
        end
    end

    // Only a strictly higher class, or any reset request, preempts a running hardware trap
    logic take;
    assign take = (req_class != SVIM_EXC_NONE) && (req_class > active_class || any_reset ||
                  (active_class == SVIM_EXC_SOFT || active_class == SVIM_EXC_NONE));

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            active_class <= SVIM_EXC_NONE;
        end else if (take) begin
            active_class <= req_class;
        end else if (trap_return) begin
            active_class <= SVIM_EXC_NONE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            trap_valid <= 1'b0;
            trap_vector_loc <= SVIM_VLOC_RESET;
            trap_number <= SVIM_TNUM_RESET;
        end else begin
            trap_valid <= take;
            if (take) begin
                trap_vector_loc <= next_loc;
                trap_number <= next_num;
            end
        end
    end

    always_comb begin
        case (active_class)
            SVIM_EXC_RESET, SVIM_EXC_CLASS_A, SVIM_EXC_CLASS_B: cpu_priority_level = SVIM_ILVL_MAX;
            default: cpu_priority_level = cpu_ilvl_in;
        endcase
    end
    assign std_irq_block = active_class >= SVIM_EXC_CLASS_B;

    // Interrupt status: shared vector requests and hardware traps
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [7:0] irq_evt;
    assign irq_evt = {2'b00, class_b, class_a, shared_vector_req};
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_status <= 8'h00;
        end else if (apb_rd && paddr == SVIM_ADDR_IST) begin
            irq_status <= irq_evt;
        end else begin
            irq_status <= irq_status | irq_evt;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_mask <= 8'h00;
        end else if (apb_wr && paddr == SVIM_ADDR_IMSK) begin
            irq_mask <= pwdata[7:0];
        end
    end
    assign irq = |(irq_status & irq_mask);

    // Read data decoded combinationally from the address during a read access
    logic [31:0] next_rdata;
    always_comb begin
        if (paddr == SVIM_ADDR_SEL0) begin
            next_rdata = {16'h0000, sel_value[0]};
        end else if (paddr == SVIM_ADDR_SEL1) begin
            next_rdata = {16'h0000, sel_value[1]};
        end else if (paddr == SVIM_ADDR_SEL2) begin
            next_rdata = {16'h0000, sel_value[2]};
        end else if (paddr == SVIM_ADDR_SEL3) begin
            next_rdata = {16'h0000, sel_value[3]};
        end else if (paddr == SVIM_ADDR_TFR) begin
            next_rdata = {16'h0000, trap_flag_register};
        end else if (paddr == SVIM_ADDR_EXC) begin
            next_rdata = {13'h0000, 3'(active_class), 4'h0, cpu_priority_level, trap_vector_loc[8:1]};
        end else if (paddr == SVIM_ADDR_IST) begin
            next_rdata = {24'h00_0000, irq_status};
        end else if (paddr == SVIM_ADDR_IMSK) begin
            next_rdata = {24'h00_0000, irq_mask};
        end else if (paddr == SVIM_ADDR_ID) begin
            next_rdata = {16'h0000, ID_VALUE};
        end else begin
            next_rdata = 32'h0000_0000;
        end
    end
    // Combinational read keeps pready tied high with zero wait states
    assign prdata = apb_rd ? next_rdata : 32'h0000_0000;
endmodule
`default_nettype wire

// ### hdl/svim_pkg.sv
`default_nettype none
package svim_pkg;
    localparam int SVIM_NUM_VEC = 4;
    localparam int SVIM_NUM_SRC = 8;
    localparam int SVIM_NUM_PER = 14;
    // Register byte addresses
    localparam logic [11:0] SVIM_ADDR_SEL0 = 12'h000;
    localparam logic [11:0] SVIM_ADDR_SEL1 = 12'h004;
    localparam logic [11:0] SVIM_ADDR_SEL2 = 12'h008;
    localparam logic [11:0] SVIM_ADDR_SEL3 = 12'h00c;
    localparam logic [11:0] SVIM_ADDR_TFR = 12'h010;
    localparam logic [11:0] SVIM_ADDR_EXC = 12'h014;
    localparam logic [11:0] SVIM_ADDR_IST = 12'h018;
    localparam logic [11:0] SVIM_ADDR_IMSK = 12'h01c;
    localparam logic [11:0] SVIM_ADDR_ID = 12'h020;
    // Select register fields
    localparam int SVIM_EN_LSB = 8;
    localparam int SVIM_FLAG_LSB = 0;
    localparam logic [15:0] SVIM_SEL_RESET = 16'h0000;
    // Trap flag register bit positions
    localparam int SVIM_TF_NMI = 15;
    localparam int SVIM_TF_STACK_OVERFLOW_FLAG = 14;
    localparam int SVIM_TF_STKUF = 13;
    localparam int SVIM_TF_UNDOP = 7;
    localparam int SVIM_TF_MACTR = 6;
    localparam int SVIM_TF_PRTFL = 3;
    localparam int SVIM_TF_ILLOP = 2;
    localparam int SVIM_TF_ILLIN = 1;
    localparam int SVIM_TF_ILLBS = 0;
    localparam logic [15:0] SVIM_TF_CLASS_B = 16'h00cf;
    // Vector locations and trap numbers
    localparam logic [8:0] SVIM_VLOC_RESET = 9'h000;
    localparam logic [8:0] SVIM_VLOC_NMI = 9'h008;
    localparam logic [8:0] SVIM_VLOC_STACK_OVERFLOW_FLAG = 9'h010;
    localparam logic [8:0] SVIM_VLOC_STKUF = 9'h018;
    localparam logic [8:0] SVIM_VLOC_CLASS_B = 9'h028;
    localparam logic [8:0] SVIM_VLOC_TOP = 9'h1fc;
    localparam logic [6:0] SVIM_TNUM_RESET = 7'h00;
    localparam logic [6:0] SVIM_TNUM_NMI = 7'h02;
    localparam logic [6:0] SVIM_TNUM_STACK_OVERFLOW_FLAG = 7'h04;
    localparam logic [6:0] SVIM_TNUM_STKUF = 7'h06;
    localparam logic [6:0] SVIM_TNUM_CLASS_B = 7'h0a;
    localparam logic [3:0] SVIM_ILVL_MAX = 4'hf;
    // Exception priority class
    typedef enum logic [2:0] {SVIM_EXC_NONE, SVIM_EXC_SOFT, SVIM_EXC_CLASS_B, SVIM_EXC_CLASS_A,
                              SVIM_EXC_RESET} svim_exc_e;
endpackage
`default_nettype wire

// ### hdl/svim_vector_slice.sv
`default_nettype none
// One shared vector: enable byte masks the flag byte
module svim_vector_slice
    import svim_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [SVIM_NUM_SRC-1:0] event_in,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    input wire logic [1:0] wr_strb,
    output logic [15:0] sel_value,
    output logic vec_req
);
    logic [SVIM_NUM_SRC-1:0] enable;
    logic [SVIM_NUM_SRC-1:0] flags;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            enable <= SVIM_SEL_RESET[SVIM_EN_LSB +: SVIM_NUM_SRC];
        end else if (wr_en && wr_strb[1]) begin
            enable <= wr_data[SVIM_EN_LSB +: SVIM_NUM_SRC];
        end
    end

    // Flags are set regardless of mask; a new event beats a same-cycle clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flags <= SVIM_SEL_RESET[SVIM_FLAG_LSB +: SVIM_NUM_SRC];
        end else if (wr_en && wr_strb[0]) begin
            flags <= wr_data[SVIM_FLAG_LSB +: SVIM_NUM_SRC] | event_in;
        end else begin
            flags <= flags | event_in;
        end
    end

    assign sel_value = {enable, flags};
    assign vec_req = |(enable & flags);
endmodule
`default_nettype wire

// ### tb/svim_checker.sv
`default_nettype none
module svim_checker
    import svim_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hw_reset_req,
    input wire logic sw_reset_req,
    input wire logic wdt_overflow_req,
    input wire logic trap_valid,
    input wire logic [8:0] trap_vector_loc,
    input wire logic [6:0] trap_number,
    input wire logic [3:0] cpu_priority_level,
    input wire logic std_irq_block
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic acc = psel && penable;
    // Soft traps are kept above the class B slot, so a low location means a hardware trap
    sequence s_hw;
        $rose(trap_valid) && trap_vector_loc <= SVIM_VLOC_CLASS_B;
    endsequence
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("access not answered");
    property p_err; acc |-> pslverr == (paddr > SVIM_ADDR_ID); endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    property p_rdz; !(acc && !pwrite) |-> prdata == 32'h0000_0000; endproperty
    a_rdz: assert property (p_rdz) else $error("read data outside read access");
    property p_pulse; trap_valid |=> !trap_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("trap valid longer than one cycle");
    property p_rst;
        $rose(hw_reset_req || sw_reset_req || wdt_overflow_req) |-> ##[1:2]
            (trap_valid && trap_vector_loc == SVIM_VLOC_RESET && trap_number == SVIM_TNUM_RESET);
    endproperty
    a_rst: assert property (p_rst) else $error("reset not vectored to zero");
    property p_loc; trap_valid |-> trap_vector_loc == {trap_number, 2'b00}; endproperty
    a_loc: assert property (p_loc) else $error("location and number disagree");
    property p_ilvl; s_hw |-> ##[0:1] cpu_priority_level == SVIM_ILVL_MAX; endproperty
    a_ilvl: assert property (p_ilvl) else $error("level not forced high");
    property p_blk; s_hw |-> ##[0:1] std_irq_block; endproperty
    a_blk: assert property (p_blk) else $error("standard requests not blocked");
    c_err: cover property (acc && pslverr);
    c_hw: cover property (s_hw);
    c_sw: cover property ($rose(trap_valid) && trap_vector_loc > SVIM_VLOC_CLASS_B);
endmodule
bind svim_top svim_checker u_chk (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .hw_reset_req, .sw_reset_req, .wdt_overflow_req, .trap_valid, .trap_vector_loc, .trap_number,
    .cpu_priority_level, .std_irq_block);
`default_nettype wire

// ### tb/svim_cpu_model.sv
`default_nettype none
module svim_cpu_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic trap_valid,
    output logic trap_return
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    logic busy;
    // Handler length varies so both short and long services are seen
    always_ff @(posedge ref_clk) begin
        trap_return <= 1'b0;
        if (reset) begin
            busy <= 1'b0;
            cnt <= 4'h0;
        end else if (trap_valid) begin
            busy <= 1'b1;
            cnt <= slow ? 4'ha : 4'h1;
        end else if (busy) begin
            if (cnt == 4'h0) begin
                busy <= 1'b0;
                trap_return <= 1'b1;
            end else begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/tb.sv
`default_nettype none
module tb;
    import svim_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, slow = 0, soft_trap_req = 0;
    logic [11:0] paddr = 0, exc = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] pstrb = 0, cpu_ilvl_in = 0, shared_vector_req, cpu_priority_level;
    logic [13:0] evt = 0;
    logic [6:0] soft_trap_num = 0, trap_number;
    logic [8:0] trap_vector_loc;
    logic [7:0] en, fl;
    logic pready, pslverr, trap_valid, trap_return, std_irq_block, irq, err;
    int num_errors = 0, n_checks = 0, cyc = 0, v, s;
    logic [3:0] rt [14] = '{9, 10, 7, 7, 8, 7, 7, 8, 7, 7, 7, 8, 8, 12};
    int tfb [12] = '{0, 0, 0, 15, 14, 13, 7, 6, 3, 2, 1, 0};
    always #20 ref_clk = ~ref_clk;
    svim_top u_dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .can1_evt(evt[0]), .can2_evt(evt[1]), .i2c_rx_evt(evt[2]), .i2c_tx_evt(evt[3]),
        .i2c_err_evt(evt[4]), .second_sync_serial_rx_evt(evt[5]), .second_sync_serial_tx_evt(evt[6]),
        .second_sync_serial_err_evt(evt[7]), .second_async_serial_rx_evt(evt[8]),
        .second_async_serial_tx_evt(evt[9]), .second_async_serial_tbuf_evt(evt[10]),
        .second_async_serial_err_evt(evt[11]), .pll_unlock_oscillator_watchdog_evt(evt[12]),
        .second_pwm_unit_evt(evt[13]), .hw_reset_req(exc[0]), .sw_reset_req(exc[1]), .wdt_overflow_req(exc[2]),
        .nmi_req(exc[3]), .stack_overflow_flag(exc[4]), .stack_underflow_flag(exc[5]),
        .undefined_opcode_flag(exc[6]), .multiply_accum_trap_flag(exc[7]), .protected_instr_fault_flag(exc[8]),
        .illegal_operand_flag(exc[9]), .illegal_fetch_flag(exc[10]), .illegal_ext_bus_flag(exc[11]),
        .soft_trap_req, .soft_trap_num, .cpu_ilvl_in, .trap_return, .shared_vector_req, .trap_valid,
        .trap_vector_loc, .trap_number, .cpu_priority_level, .std_irq_block, .irq);
    svim_cpu_model u_cpu (.ref_clk, .reset, .slow, .trap_valid, .trap_return);
    task automatic results();
        if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            results();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
        @(posedge ref_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= st;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic pulse(input int e);
        @(posedge ref_clk);
        evt <= 14'(1) << e;
        @(posedge ref_clk);
        evt <= 0;
        repeat (2) @(posedge ref_clk);
    endtask
    function automatic logic [6:0] tnum(input int i);
        return i < 3 ? 7'h00 : i < 6 ? 7'(2 * i - 4) : 7'h0a;
    endfunction
    task automatic trap(input int i, input logic sw);
        logic [6:0] num;
        @(posedge ref_clk);
        num = sw ? soft_trap_num : tnum(i);
        if (sw) soft_trap_req <= 1; else exc <= 12'(1) << i;
        @(posedge ref_clk);
        soft_trap_req <= 0; exc <= 0;
        do @(negedge ref_clk); while (trap_valid !== 1'b1);
        check(trap_vector_loc, {num, 2'b00});
        check(trap_number, num);
        check(cpu_priority_level, sw ? cpu_ilvl_in : SVIM_ILVL_MAX);
        if (!sw) check(std_irq_block, 1);
        do @(negedge ref_clk); while (trap_return !== 1'b1);
        if (i > 2 && !sw) begin
            apb(0, SVIM_ADDR_TFR, 0, 0);
            check(rd[15:0], 16'(1) << tfb[i]);
            apb(1, SVIM_ADDR_TFR, 0, 4'h3);
        end
    endtask
    initial begin
        s = $urandom(23);
        repeat (20) @(posedge ref_clk);
        reset <= 0;
        for (int r = 0; r < 8; r++) begin apb(0, 12'(4 * r), 0, 0); check(rd, 0); end
        // Corner first: disjoint enable and flag bytes must not request
        for (int t = 0; t < 12; t++) begin
            v = $urandom % 4;
            en = t == 0 ? 8'h80 : 8'($urandom);
            fl = t == 0 ? 8'h7f : 8'($urandom);
            apb(1, 12'(4 * v), {16'h0000, en, fl}, 4'h3);
            apb(0, 12'(4 * v), 0, 0);
            check(rd, {16'h0000, en, fl});
            check(shared_vector_req[v], |(en & fl));
            apb(1, 12'(4 * v), 0, 4'h2);
            apb(0, 12'(4 * v), 0, 0);
            check(rd, {24'h00_0000, fl});
            apb(1, 12'(4 * v), 0, 4'h1);
        end
        // Masked sources still flag, and flags stay until software clears them
        for (int e = 0; e < 14; e++) begin
            pulse(e);
            check(shared_vector_req, 0);
            for (int x = 0; x < 4; x++) begin
                apb(0, 12'(4 * x), 0, 0);
                check(rd[7:0] != 0, rt[e][x]);
                apb(1, 12'(4 * x), 0, 4'h1);
            end
        end
        // Status is sticky from the random requests above, so clear it before unmasking
        apb(0, SVIM_ADDR_IST, 0, 0);
        apb(1, SVIM_ADDR_IMSK, 1, 4'hf);
        @(negedge ref_clk) check(irq, 0);
        apb(1, SVIM_ADDR_SEL0, 32'h0000_ff00, 4'h3);
        pulse(0);
        @(negedge ref_clk) check(irq, 1);
        apb(1, SVIM_ADDR_IMSK, 0, 4'hf);
        @(negedge ref_clk) check(irq, 0);
        apb(1, SVIM_ADDR_IMSK, 1, 4'hf);
        apb(1, SVIM_ADDR_SEL0, 0, 4'h3);
        apb(0, SVIM_ADDR_IST, 0, 0);
        check(rd[0], 1);
        @(negedge ref_clk) check(irq, 0);
        apb(0, 12'h024, 0, 0);
        check({err, rd}, {1'b1, 32'h0000_0000});
        for (int i = 0; i < 12; i++) begin
            slow <= i[0];
            trap(i, 0);
        end
        // A class A trap preempts a class B service, the reverse is refused
        slow <= 1;
        @(posedge ref_clk) exc <= 12'h040;
        @(posedge ref_clk) exc <= 0;
        @(posedge ref_clk) exc <= 12'h008;
        @(posedge ref_clk) exc <= 0;
        @(negedge ref_clk) check({trap_valid, trap_vector_loc}, {1'b1, SVIM_VLOC_NMI});
        @(posedge ref_clk) exc <= 12'h040;
        @(posedge ref_clk) exc <= 0;
        @(negedge ref_clk) check({trap_valid, cpu_priority_level}, {1'b0, SVIM_ILVL_MAX});
        while (trap_return !== 1'b1) @(negedge ref_clk);
        apb(1, SVIM_ADDR_TFR, 0, 4'h3);
        for (int j = 0; j < 4; j++) begin
            @(posedge ref_clk);
            soft_trap_num <= 7'(16 + $urandom % 112);
            cpu_ilvl_in <= 4'($urandom);
            trap(0, 1);
        end
        results();
    end
endmodule
`default_nettype wire
